// File: sim/acb_scan_ctrl_sva.sv
/* Port checker of acb_scan_ctrl.
   Assumes hready is fed back from hreadyout by the bench. */
`default_nettype none
`include "acb_defs.svh"
module acb_scan_ctrl_sva #(
  parameter int unsigned RESULT_SLOTS = `ACB_RESULT_SLOTS
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [2:0]  scan_mode,
  input wire logic        b_scan_end,
  input wire logic        conv_result_valid,
  input wire logic [1:0]  conv_result_index,
  input wire logic [15:0] conv_result_data,
  input wire logic        b_scan_start,
  input wire logic        b_scan_stop,
  input wire logic        b_scan_active_flag,
  input wire logic        result_valid,
  input wire logic [1:0]  result_index,
  input wire logic [15:0] result_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_rd; hsel && htrans[1] && hready && !hwrite; endsequence
  sequence s_wait; !hreadyout ##1 hreadyout; endsequence
  a_read_one_wait: assert property (s_rd |=> s_wait)
    else $error("read wait wrong");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bad response");
  a_start_active: assert property (b_scan_start |-> ##[0:1] b_scan_active_flag)
    else $error("start without active");
  // Loop restarts follow an end, so only quiet cycles forbid a start
  a_no_restart: assert property (b_scan_active_flag && !b_scan_end && !$past(b_scan_end) |=> !b_scan_start)
    else $error("start during scan");
  a_end_idle: assert property (scan_mode[2:1] != 2'b01 && b_scan_active_flag && b_scan_end
    |=> !b_scan_active_flag)
    else $error("active after end");
  a_stop_idle: assert property (b_scan_stop |-> !b_scan_active_flag)
    else $error("active after stop");
  a_seq_quiet: assert property (!scan_mode[0] |-> !b_scan_start)
    else $error("start in sequential mode");
  a_result_path: assert property (conv_result_valid |=> result_valid
    && result_index == $past(conv_result_index) && result_data == $past(conv_result_data))
    else $error("result lost");
endmodule // acb_scan_ctrl_sva
bind acb_scan_ctrl acb_scan_ctrl_sva #(.RESULT_SLOTS(RESULT_SLOTS)) i_acb_scan_ctrl_sva (.clk(clk), .reset(reset),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .scan_mode(scan_mode), .b_scan_end(b_scan_end), .conv_result_valid(conv_result_valid),
  .conv_result_index(conv_result_index), .conv_result_data(conv_result_data), .b_scan_start(b_scan_start),
  .b_scan_stop(b_scan_stop), .b_scan_active_flag(b_scan_active_flag), .result_valid(result_valid),
  .result_index(result_index), .result_data(result_data));
`default_nettype wire

// File: sim/acb_scan_ctrl_tb.sv
/* Bench of acb_scan_ctrl with the sequencer model.
   Assumes a 40 MHz clock and one bus master. */
`default_nettype none
`include "acb_defs.svh"
module acb_scan_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] C_HALT = 32'h0000_4000;
  localparam logic [31:0] C_GO = 32'h0000_2000;
  localparam logic [31:0] C_TRG = 32'h0000_1000;
  localparam logic [31:0] C_IEN = 32'h0000_0800;
  logic clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, pin = 1'b0, cval = 1'b0;
  logic a_go = 1'b0, a_end = 1'b0;
  logic [1:0] htrans = 2'h0, cidx = 2'h0, ri;
  logic [2:0] hsize = 3'h2, mode = 3'h1;
  logic [7:0] lat = 8'h0a;
  logic [15:0] cdat = 16'h0, rd;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, n_start = 32'h0, cyc = 32'h0, n_tests = 32'h0, fails = 32'h0;
  logic [31:0] rdat = 32'h0, q, n0, hrdata;
  logic hreadyout, hresp, start, stop, act, irq, send, rv;
  always #12.5 clk = ~clk;
  acb_scan_ctrl i_acb_scan_ctrl (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .scan_mode(mode), .a_scan_start(a_go), .a_scan_end(a_end), .b_scan_end(send),
    .b_trigger_pin(pin), .conv_result_valid(cval), .conv_result_index(cidx), .conv_result_data(cdat),
    .b_scan_start(start), .b_scan_stop(stop), .b_scan_active_flag(act), .b_scan_done_irq(irq),
    .result_valid(rv), .result_index(ri), .result_data(rd));
  acb_seq_model i_acb_seq_model (.clk(clk), .reset(reset), .start(start), .stop(stop), .lat(lat), .scan_end(send));
  always @(posedge clk) begin
    cyc <= cyc + 32'h1;
    if (start === 1'b1) n_start <= n_start + 32'h1;
    if (rv === 1'b1) rdat <= {14'h0, ri, rd};
    if (cyc == 32'h0000_1388) begin
      fails = fails + 32'h1;
      conclude;
    end
  end
  task automatic nap(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Ready and read data are taken at the rising edge, before the design updates them
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0_0000, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests = n_tests + 32'h1;
    if (got !== exp) begin
      fails = fails + 32'h1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pulse;
    pin <= 1'b1;
    nap(3);
    pin <= 1'b0;
    nap(1);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 32'h0 && n_tests != 32'h0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_base;
    bus(1'b0, `ACB_OFS_CTRL, 32'h0);
    chk(q, 32'h0000_0020);
    bus(1'b0, 12'h008, 32'h0);
    chk(q, 32'h0);
    n0 = n_start;
    bus(1'b1, `ACB_OFS_CTRL, C_GO | 32'h0000_0020);
    nap(4);
    chk(n_start - n0, 32'h0);
    a_go <= 1'b1;
    nap(1);
    a_go <= 1'b0;
    nap(2);
    chk(n_start - n0, 32'h1);
    chk(32'(act), 32'h1);
    a_end <= 1'b1;
    nap(1);
    a_end <= 1'b0;
    nap(2);
    chk(32'(act), 32'h0);
    mode <= 3'h0;
    bus(1'b1, `ACB_OFS_CTRL, C_GO);
    nap(4);
    chk(n_start - n0, 32'h1);
    mode <= 3'h1;
    $display("test base done");
  endtask
  task automatic t_go;
    n0 = n_start;
    bus(1'b1, `ACB_OFS_CTRL, C_GO | C_IEN);
    nap(2);
    chk(n_start - n0, 32'h1);
    chk(32'(act), 32'h1);
    bus(1'b1, `ACB_OFS_CTRL, C_GO | C_IEN);
    bus(1'b1, `ACB_OFS_CTRL, C_IEN);
    nap(12);
    chk(n_start - n0, 32'h1);
    chk(32'(irq), 32'h1);
    bus(1'b0, `ACB_OFS_STATUS, 32'h0);
    chk(q, 32'h2);
    bus(1'b1, `ACB_OFS_STATUS, 32'h2);
    nap(2);
    chk(32'(irq), 32'h0);
    $display("test start done");
  endtask
  task automatic t_trig;
    lat <= 8'h14;
    n0 = n_start;
    bus(1'b1, `ACB_OFS_CTRL, C_TRG);
    pulse;
    nap(6);
    chk(n_start - n0, 32'h1);
    bus(1'b1, `ACB_OFS_CTRL, C_TRG);
    pulse;
    nap(16);
    chk(n_start - n0, 32'h1);
    pulse;
    nap(6);
    chk(n_start - n0, 32'h2);
    nap(20);
    pulse;
    nap(6);
    chk(n_start - n0, 32'h2);
    bus(1'b1, `ACB_OFS_CTRL, 32'h0);
    pulse;
    nap(6);
    chk(n_start - n0, 32'h2);
    $display("test trigger done");
  endtask
  task automatic t_halt;
    n0 = n_start;
    bus(1'b1, `ACB_OFS_CTRL, C_GO);
    nap(3);
    bus(1'b1, `ACB_OFS_CTRL, C_HALT | C_TRG);
    nap(2);
    chk(32'(act), 32'h0);
    bus(1'b1, `ACB_OFS_CTRL, C_HALT | C_TRG | C_GO);
    pulse;
    nap(6);
    chk(n_start - n0, 32'h1);
    bus(1'b1, `ACB_OFS_RESULT0 + 12'h004, 32'h0000_1234);
    nap(2);
    chk(rdat, 32'h0001_1234);
    cidx <= 2'h2;
    cdat <= 16'hbeef;
    cval <= 1'b1;
    nap(1);
    cval <= 1'b0;
    nap(2);
    chk(rdat, 32'h0002_beef);
    bus(1'b1, `ACB_OFS_CTRL, C_GO);
    nap(3);
    chk(n_start - n0, 32'h2);
    bus(1'b1, `ACB_OFS_RESULT0, 32'h0000_5678);
    nap(2);
    chk(rdat, 32'h0002_beef);
    $display("test halt done");
  endtask
  task automatic t_loop;
    nap(25);
    lat <= 8'h04;
    mode <= 3'h3;
    n0 = n_start;
    bus(1'b1, `ACB_OFS_CTRL, C_GO);
    nap(20);
    chk(32'(n_start - n0 > 32'h2), 32'h1);
    bus(1'b1, `ACB_OFS_CTRL, C_HALT);
    nap(2);
    n0 = n_start;
    nap(10);
    chk(n_start - n0, 32'h0);
    chk(32'(act), 32'h0);
    $display("test loop done");
  endtask
  initial begin
    nap(4);
    reset <= 1'b0;
    nap(1);
    t_base;
    t_go;
    t_trig;
    t_halt;
    t_loop;
    conclude;
  end
endmodule // acb_scan_ctrl_tb
`default_nettype wire

// File: sim/acb_seq_model.sv
/* Converter B sequencer model: ends a scan lat cycles after its start.
   Assumes start and stop are one-cycle pulses on clk. */
`default_nettype none
module acb_seq_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       start,
  input  wire logic       stop,
  input  wire logic [7:0] lat,
  output logic            scan_end
);
  logic [7:0] cnt_ff;
  // An aborted scan must not end later, so stop clears the count
  always_ff @(posedge clk) begin
    if (reset || stop) begin
      cnt_ff   <= 8'h00;
      scan_end <= 1'b0;
    end else if (start) begin
      cnt_ff   <= lat;
      scan_end <= 1'b0;
    end else begin
      scan_end <= (cnt_ff == 8'h01);
      if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
    end
  end
endmodule // acb_seq_model
`default_nettype wire

// File: verilog/acb_defs.svh
/*
  Offsets, field positions, reset values and counts of the converter B scan control block.
  Assumes inclusion by its bare name from the package and the design modules.
*/
`ifndef ACB_DEFS_SVH
`define ACB_DEFS_SVH

// Register byte offsets and result slot count
`define ACB_OFS_CTRL        12'h000
`define ACB_OFS_STATUS      12'h004
`define ACB_OFS_RESULT0     12'h010
`define ACB_RESULT_SLOTS    4

// Control register fields
`define ACB_CTRL_HALT       14
`define ACB_CTRL_LAUNCH     13
`define ACB_CTRL_TRIG_EN    12
`define ACB_CTRL_IRQ_EN     11
`define ACB_CTRL_LOCKSTEP   5
`define ACB_CTRL_DIV_MSB    4
`define ACB_DIV_W           5

// Status register fields
`define ACB_STAT_ACTIVE     0
`define ACB_STAT_DONE       1

// Reset values
`define ACB_LOCKSTEP_RST    1'b1
`define ACB_DIV_RST         5'h00

// Scan mode codes
`define ACB_MODE_W          3
`define ACB_MODE_PAR_BIT    0
`define ACB_MODE_ONCE       2'b00
`define ACB_MODE_LOOP       2'b01

// Synchroniser depth
`define ACB_SYNC_STAGES     2

`endif

// File: verilog/acb_pkg.sv
/*
  Types of the converter B scan control block.
  Assumes acb_defs.svh is on the include path.
*/
`default_nettype none
`include "acb_defs.svh"

package acb_pkg;

  // Gray order: idle -> scan -> idle
  typedef enum logic [0:0] {
    ACB_ST_IDLE = 1'b0,
    ACB_ST_SCAN = 1'b1
  } acb_state_t;

  typedef struct packed {
    logic                       rd_pend_ff;
    logic                       wr_pend_ff;
    logic [11:0]                addr_ff;
    logic                       hready_ff;
    logic [31:0]                hrdata_ff;
    logic                       halt_ff;
    logic                       trig_en_ff;
    logic                       irq_en_ff;
    logic                       lockstep_ff;
    logic [`ACB_DIV_W-1:0]      div_ff;
    logic                       armed_ff;
    logic                       done_ff;
    acb_state_t                 state_ff;
    logic                       start_ff;
    logic                       stop_ff;
    logic                       irq_ff;
    logic                       res_valid_ff;
    logic [1:0]                 res_index_ff;
    logic [15:0]                res_data_ff;
  } acb_state_s_t;

endpackage : acb_pkg

`default_nettype wire

// File: verilog/acb_scan_ctrl.sv
/*
  Converter B scan control: control/status registers over AHB-Lite, start, halt and
  hardware trigger handling, scan tracking, end-of-scan interrupt, processor result writes.
  Assumes one clock, a synchronous active-high reset, a single AHB-Lite master, and a
  converter B sequencer that pulses scan_end when its list ends or a disabled slot is met.
*/
// Summary of operation
// - In parallel scan modes the control register governs converter B scans.
// - Lockstep set (default): B follows A; B halt, start, trigger, irq bits ignored.
// - Lockstep clear: B halt, start, trigger enable and trigger pin run B alone.
// - Independent: irq enable gates the B end-of-scan interrupt.
// - Independent: scan-active flag stands while a B scan runs.
// - Independent: halt stops B scans and blocks new ones.
// - While halted, trigger pulses and start writes are ignored.
// - Once halted, the processor may write the result registers.
// - Processor result writes travel the same path as converter data.
// - Writing 1 to write-only start begins a B scan; 0 does nothing.
// - A start write during a running scan is ignored.
// - Trigger enabled: rising edge on trigger pin starts a B scan.
// - Trigger disabled: only a start write begins a scan.
// - Trigger pulses during a running scan are ignored.
// - Once modes honour one trigger pulse until trigger enable is rewritten.
// - Re-arming the trigger is accepted at any time, even mid-scan.
// - Lockstep: a scan ends in both converters when either meets a disabled slot.
// - Independent: B scans its own list; loop mode restarts until halted.
`default_nettype none
`include "acb_defs.svh"

module acb_scan_ctrl #(
  parameter int unsigned RESULT_SLOTS = `ACB_RESULT_SLOTS
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  input  wire logic [`ACB_MODE_W-1:0] scan_mode,
  input  wire logic                   a_scan_start,
  input  wire logic                   a_scan_end,
  input  wire logic                   b_scan_end,
  input  wire logic                   b_trigger_pin,
  input  wire logic                   conv_result_valid,
  input  wire logic [1:0]             conv_result_index,
  input  wire logic [15:0]            conv_result_data,
  output logic                        b_scan_start,
  output logic                        b_scan_stop,
  output logic                        b_scan_active_flag,
  output logic                        b_scan_done_irq,
  output logic                        result_valid,
  output logic [1:0]                  result_index,
  output logic [15:0]                 result_data
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check
  if (RESULT_SLOTS != 4) begin : g_bad_slots
    $error("acb_scan_ctrl: RESULT_SLOTS must be 4");
  end

  if (`ACB_SYNC_STAGES < 2) begin : g_bad_sync
    $error("acb_scan_ctrl: trigger synchroniser needs at least two stages");
  end

  if (`ACB_DIV_W != `ACB_CTRL_DIV_MSB + 1) begin : g_bad_div
    $error("acb_scan_ctrl: divider field width does not match its position");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic is_result_addr(input logic [11:0] a);
    is_result_addr = (a >= `ACB_OFS_RESULT0) && (a < `ACB_OFS_RESULT0 + 12'h010) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [1:0] result_slot(input logic [11:0] a);
    result_slot = a[3:2];
  endfunction

  function automatic logic is_ctrl_addr(input logic [11:0] a);
    is_ctrl_addr = (a == `ACB_OFS_CTRL);
  endfunction

  function automatic logic is_stat_addr(input logic [11:0] a);
    is_stat_addr = (a == `ACB_OFS_STATUS);
  endfunction

  // Launch bit is write-only, so it always reads back as 0
  function automatic logic [31:0] ctrl_image(input acb_pkg::acb_state_s_t s);
    ctrl_image                      = 32'h0000_0000;
    ctrl_image[`ACB_CTRL_HALT]      = s.halt_ff;
    ctrl_image[`ACB_CTRL_TRIG_EN]   = s.trig_en_ff;
    ctrl_image[`ACB_CTRL_IRQ_EN]    = s.irq_en_ff;
    ctrl_image[`ACB_CTRL_LOCKSTEP]  = s.lockstep_ff;
    ctrl_image[`ACB_CTRL_DIV_MSB:0] = s.div_ff;
  endfunction

  function automatic logic [31:0] stat_image(input acb_pkg::acb_state_s_t s, input logic ind);
    stat_image                   = 32'h0000_0000;
    stat_image[`ACB_STAT_ACTIVE] = (s.state_ff == acb_pkg::ACB_ST_SCAN) & ind;
    stat_image[`ACB_STAT_DONE]   = s.done_ff;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Trigger pin
  logic trig_rise;

  acb_sync_edge u_sync (
    .clk   (clk),
    .reset (reset),
    .pin   (b_trigger_pin),
    .rise  (trig_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State
  acb_pkg::acb_state_s_t cur;
  acb_pkg::acb_state_s_t nxt_cur;

  logic        addr_phase;
  logic        parallel;
  logic        once_mode;
  logic        loop_mode;
  logic        indep;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        wr_res;
  logic        sw_start;
  logic        hw_start;
  logic        begin_scan;
  logic        end_scan;
  logic        halt_now;
  logic [31:0] rd_val;

  always_comb begin
    nxt_cur = cur;

    addr_phase = hsel & htrans[1] & hready;
    parallel   = scan_mode[`ACB_MODE_PAR_BIT];
    once_mode  = (scan_mode[2:1] == `ACB_MODE_ONCE);
    loop_mode  = (scan_mode[2:1] == `ACB_MODE_LOOP);
    indep      = parallel & ~cur.lockstep_ff;

    // Write data phase: zero wait states
    wr_ctrl = cur.wr_pend_ff & is_ctrl_addr(cur.addr_ff);
    wr_stat = cur.wr_pend_ff & is_stat_addr(cur.addr_ff);
    wr_res  = cur.wr_pend_ff & is_result_addr(cur.addr_ff);

    if (wr_ctrl) begin
      nxt_cur.halt_ff     = hwdata[`ACB_CTRL_HALT];
      nxt_cur.trig_en_ff  = hwdata[`ACB_CTRL_TRIG_EN];
      nxt_cur.irq_en_ff   = hwdata[`ACB_CTRL_IRQ_EN];
      nxt_cur.lockstep_ff = hwdata[`ACB_CTRL_LOCKSTEP];
      nxt_cur.div_ff      = hwdata[`ACB_CTRL_DIV_MSB:0];
    end

    // Any write with trigger enable set re-arms, scanning or not
    if (wr_ctrl && hwdata[`ACB_CTRL_TRIG_EN]) begin
      nxt_cur.armed_ff = 1'b1;
    end else if (wr_ctrl) begin
      nxt_cur.armed_ff = 1'b0;
    end

    // Halt takes effect with the write that sets it
    halt_now = wr_ctrl ? hwdata[`ACB_CTRL_HALT] : cur.halt_ff;

    // Start sources; blocked while halted or already scanning
    sw_start = wr_ctrl & hwdata[`ACB_CTRL_LAUNCH];
    hw_start = trig_rise & cur.trig_en_ff & (cur.armed_ff | ~once_mode);
    begin_scan = 1'b0;
    end_scan   = 1'b0;

    nxt_cur.start_ff = 1'b0;
    nxt_cur.stop_ff  = 1'b0;

    if (!parallel) begin
      // Sequential modes: register has its other meaning, B is left alone
      nxt_cur.state_ff = acb_pkg::ACB_ST_IDLE;
    end else if (cur.lockstep_ff) begin
      // B mirrors A; B-only controls have no effect
      unique case (cur.state_ff)
        acb_pkg::ACB_ST_IDLE: begin
          if (a_scan_start) begin
            nxt_cur.state_ff = acb_pkg::ACB_ST_SCAN;
            nxt_cur.start_ff = 1'b1;
          end
        end
        acb_pkg::ACB_ST_SCAN: begin
          if (a_scan_end || b_scan_end) begin
            nxt_cur.state_ff = acb_pkg::ACB_ST_IDLE;
            nxt_cur.stop_ff  = 1'b1;
          end
        end
      endcase
    end else begin
      unique case (cur.state_ff)
        acb_pkg::ACB_ST_IDLE: begin
          if (!halt_now && (sw_start || hw_start)) begin
            begin_scan = 1'b1;
          end
        end
        acb_pkg::ACB_ST_SCAN: begin
          // Start writes and trigger pulses here are dropped
          if (halt_now) begin
            nxt_cur.state_ff = acb_pkg::ACB_ST_IDLE;
            nxt_cur.stop_ff  = 1'b1;
          end else if (b_scan_end) begin
            end_scan = 1'b1;
            if (loop_mode) begin
              nxt_cur.start_ff = 1'b1;
            end else begin
              nxt_cur.state_ff = acb_pkg::ACB_ST_IDLE;
            end
          end
        end
      endcase
    end

    if (begin_scan) begin
      nxt_cur.state_ff = acb_pkg::ACB_ST_SCAN;
      nxt_cur.start_ff = 1'b1;
      // A re-arm write in the same cycle wins over consuming the trigger
      if (hw_start && once_mode && !(wr_ctrl && hwdata[`ACB_CTRL_TRIG_EN])) begin
        nxt_cur.armed_ff = 1'b0;
      end
    end

    // Done flag: set beats a write-one clear in the same cycle
    if (end_scan) begin
      nxt_cur.done_ff = 1'b1;
    end else if (wr_stat && hwdata[`ACB_STAT_DONE]) begin
      nxt_cur.done_ff = 1'b0;
    end

    nxt_cur.irq_ff = nxt_cur.done_ff & cur.irq_en_ff & indep;

    // Result path: processor writes only while halted in independent mode
    if (wr_res && cur.halt_ff && indep) begin
      nxt_cur.res_valid_ff = 1'b1;
      nxt_cur.res_index_ff = result_slot(cur.addr_ff);
      nxt_cur.res_data_ff  = hwdata[15:0];
    end else begin
      nxt_cur.res_valid_ff = conv_result_valid;
      nxt_cur.res_index_ff = conv_result_index;
      nxt_cur.res_data_ff  = conv_result_data;
    end

    // Bus: reads take one wait state so writes ahead of them are seen
    nxt_cur.wr_pend_ff = 1'b0;
    rd_val = 32'h0000_0000;
    if (is_ctrl_addr(cur.addr_ff)) begin
      rd_val = ctrl_image(cur);
    end else if (is_stat_addr(cur.addr_ff)) begin
      rd_val = stat_image(cur, indep);
    end

    if (cur.rd_pend_ff) begin
      nxt_cur.rd_pend_ff = 1'b0;
      nxt_cur.hready_ff  = 1'b1;
      nxt_cur.hrdata_ff  = rd_val;
    end else if (addr_phase) begin
      nxt_cur.addr_ff    = haddr[11:0];
      nxt_cur.rd_pend_ff = ~hwrite;
      nxt_cur.wr_pend_ff = hwrite;
      nxt_cur.hready_ff  = hwrite;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk) begin
    if (reset) begin
      cur             <= '0;
      cur.hready_ff   <= 1'b1;
      cur.lockstep_ff <= `ACB_LOCKSTEP_RST;
      cur.div_ff      <= `ACB_DIV_RST;
      cur.state_ff    <= acb_pkg::ACB_ST_IDLE;
    end else begin
      cur <= nxt_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs from flip-flops, except hresp, which is tied to 0
  assign hreadyout          = cur.hready_ff;
  assign hresp              = 1'b0;
  assign hrdata             = cur.hrdata_ff;
  assign b_scan_start       = cur.start_ff;
  assign b_scan_stop        = cur.stop_ff;
  assign b_scan_active_flag = (cur.state_ff == acb_pkg::ACB_ST_SCAN);
  assign b_scan_done_irq    = cur.irq_ff;
  assign result_valid       = cur.res_valid_ff;
  assign result_index       = cur.res_index_ff;
  assign result_data        = cur.res_data_ff;

endmodule // acb_scan_ctrl

`default_nettype wire

// File: verilog/acb_sync_edge.sv
/*
  Two-stage synchroniser with rising edge detector for the converter B trigger pin.
  Assumes the pin is asynchronous to clk; one pulse out per rising edge.
*/
`default_nettype none
`include "acb_defs.svh"

module acb_sync_edge (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic pin,
  output logic      rise
);

  logic [`ACB_SYNC_STAGES-1:0] sync_ff;
  logic                        last_ff;
  logic                        rise_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Only the last stage feeds the edge detector
  always_ff @(posedge clk) begin
    if (reset) begin
      sync_ff <= '0;
      last_ff <= 1'b0;
      rise_ff <= 1'b0;
    end else begin
      sync_ff <= {sync_ff[`ACB_SYNC_STAGES-2:0], pin};
      last_ff <= sync_ff[`ACB_SYNC_STAGES-1];
      rise_ff <= sync_ff[`ACB_SYNC_STAGES-1] & ~last_ff;
    end
  end

  assign rise = rise_ff;

endmodule // acb_sync_edge

`default_nettype wire
